//--- src/battery_protection_pkg.sv
package battery_protection_pkg;

    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int             DATA_W        = 32;
    localparam int             ADDR_W        = 8;
    localparam logic [7:0]     CTRL_ADDR     = 8'h00;
    localparam logic [7:0]     FLAGS_ADDR    = 8'h04;
    localparam logic [7:0]     INT_STS_ADDR  = 8'h08;
    localparam logic [7:0]     INT_MASK_ADDR = 8'h0c;
    localparam logic [7:0]     LEVEL_BASE    = 8'h10;
    localparam logic [7:0]     DELAY_BASE    = 8'h30;
    localparam logic [7:0]     ADDR_LAST     = 8'h3c;
    localparam logic [1:0]     RESP_OKAY     = 2'h0;
    localparam logic [1:0]     RESP_SLVERR   = 2'h2;

    // ****************************************
    // Channels and flag positions
    // ****************************************
    localparam int             CH_OV         = 0;
    localparam int             CH_UV         = 1;
    localparam int             CH_OTC        = 2;
    localparam int             CH_OTD        = 3;
    localparam int             N_CH          = 4;
    localparam int             FLAG_ISD      = 4;
    localparam int             FLAG_TDD      = 5;
    localparam int             N_FLAGS       = 6;
    localparam int             LEVEL_W       = 16;
    localparam int             DELAY_W       = 16;
    localparam logic [5:0]     ALERT_SOURCES = 6'h3c;

    // ****************************************
    // Reset values, channel 3 first
    // ****************************************
    localparam logic [3:0][15:0] THR_RST = {16'hffff, 16'hffff, 16'h0000, 16'hffff};
    localparam logic [3:0][15:0] REC_RST = {16'h0000, 16'h0000, 16'hffff, 16'h0000};
    localparam logic [3:0][15:0] DLY_RST = {16'h0000, 16'h0000, 16'h0001, 16'h0001};
    localparam logic [5:0]     MASK_RST      = 6'h00;

    // ****************************************
    // Timing: delays count in 1 ms ticks
    // ****************************************
    localparam int             CLK_PERIOD_NS = 20;
    localparam int             TICK_NS       = 1000000;
    localparam int             TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] temperature;
    } meas_t;

    typedef struct packed {
        logic battery_trip_point_enable;
        logic host_interrupt_enable;
        logic overtemp_opens_switch;
    } ctrl_t;

endpackage

//--- src/battery_protection.sv
`timescale 1ns/1ns
// Summary of operation
// - Voltage held at or above the overvoltage threshold for the overvoltage delay opens the charge switch and sets the overvoltage flag, both undone once voltage is at or below the overvoltage recovery level.
// - Voltage held at or below the undervoltage threshold for the undervoltage delay opens the discharge switch and sets the undervoltage flag, both undone once voltage is at or above the undervoltage recovery level.
// - Temperature held at or above the charge overtemperature limit for the charge overtemperature time sets the charge overtemperature flag, cleared at or below its recovery level.
// - With overtemp_opens_switch set, charge overtemperature also opens the charge switch until recovery; otherwise only the flag is set.
// - A charge overtemperature time of zero disables that check entirely.
// - Charge overtemperature can raise the host alert pin.
// - Charge and discharge overtemperature, internal short and tab disconnect reach the alert pin only with host interrupt enable set and battery trip point enable clear.
// - Each safety event opens its switch, sets its flag, or both, as its protection defines.
// - Discharge overtemperature sets its flag after its time, opens the discharge switch when overtemp_opens_switch is set, and a time of zero disables it.
module battery_protection #(
    parameter int TICK_CYCLES = battery_protection_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    // AXI4-Lite write channels
    input  wire logic [7:0]                    s_axi_awaddr_i,
    input  wire logic                          s_axi_awvalid_i,
    output logic                               s_axi_awready_o,
    input  wire logic [31:0]                   s_axi_wdata_i,
    input  wire logic [3:0]                    s_axi_wstrb_i,
    input  wire logic                          s_axi_wvalid_i,
    output logic                               s_axi_wready_o,
    output logic [1:0]                         s_axi_bresp_o,
    output logic                               s_axi_bvalid_o,
    input  wire logic                          s_axi_bready_i,
    // AXI4-Lite read channels
    input  wire logic [7:0]                    s_axi_araddr_i,
    input  wire logic                          s_axi_arvalid_i,
    output logic                               s_axi_arready_o,
    output logic [31:0]                        s_axi_rdata_o,
    output logic [1:0]                         s_axi_rresp_o,
    output logic                               s_axi_rvalid_o,
    input  wire logic                          s_axi_rready_i,
    // Measurements and detector results
    input  wire battery_protection_pkg::meas_t meas_i,
    input  wire logic                          internal_short_detect_i,
    input  wire logic                          tab_disconnect_detect_i,
    // Switches, flags and interrupts
    output logic                               charge_switch_o,
    output logic                               discharge_switch_o,
    output logic [5:0]                         safety_flag_word_o,
    output logic                               irq_o,
    output logic                               host_alert_pin_o
);

    initial begin
        if (TICK_CYCLES < 1) begin
            $error("TICK_CYCLES must be at least 1");
        end
    end

    // ****************************************
    // Register storage
    // ****************************************
    battery_protection_pkg::ctrl_t ctrl;
    logic [3:0][15:0]              thr;
    logic [3:0][15:0]              rec;
    logic [3:0][15:0]              dly;
    logic [5:0]                    int_sts;
    logic [5:0]                    int_mask;
    logic [5:0]                    flags;
    logic [5:0]                    flags_prev;

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_do;
    logic        wr_hit;
    logic [5:0]  sts_clr;

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign wr_do           = aw_held && w_held && !s_axi_bvalid_o;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= battery_protection_pkg::ADDR_LAST);
    endfunction

    assign wr_hit = addr_ok(aw_addr);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end else if (wr_do) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end else if (wr_do) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= battery_protection_pkg::RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? battery_protection_pkg::RESP_OKAY
                                     : battery_protection_pkg::RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Register writes; read-only flag word ignores writes
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl     <= '0;
            thr      <= battery_protection_pkg::THR_RST;
            rec      <= battery_protection_pkg::REC_RST;
            dly      <= battery_protection_pkg::DLY_RST;
            int_mask <= battery_protection_pkg::MASK_RST;
        end else if (wr_do && wr_hit) begin
            if (aw_addr == battery_protection_pkg::CTRL_ADDR) begin
                ctrl <= 3'(merge(32'(ctrl), w_data, w_strb));
            end
            if (aw_addr == battery_protection_pkg::INT_MASK_ADDR) begin
                int_mask <= 6'(merge(32'(int_mask), w_data, w_strb));
            end
            for (int k = 0; k < battery_protection_pkg::N_CH; k++) begin
                if (aw_addr == 8'(battery_protection_pkg::LEVEL_BASE + 8 * k)) begin
                    thr[k] <= 16'(merge(32'(thr[k]), w_data, w_strb));
                end
                if (aw_addr == 8'(battery_protection_pkg::LEVEL_BASE + 8 * k + 4)) begin
                    rec[k] <= 16'(merge(32'(rec[k]), w_data, w_strb));
                end
                if (aw_addr == 8'(battery_protection_pkg::DELAY_BASE + 4 * k)) begin
                    dly[k] <= 16'(merge(32'(dly[k]), w_data, w_strb));
                end
            end
        end
    end

    assign sts_clr = (wr_do && aw_addr == battery_protection_pkg::INT_STS_ADDR)
                     ? (6'(w_data) & {6{w_strb[0]}}) : 6'h00;

    // Read data path
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == battery_protection_pkg::CTRL_ADDR) begin
            v = 32'(ctrl);
        end
        if (a == battery_protection_pkg::FLAGS_ADDR) begin
            v = 32'(flags);
        end
        if (a == battery_protection_pkg::INT_STS_ADDR) begin
            v = 32'(int_sts);
        end
        if (a == battery_protection_pkg::INT_MASK_ADDR) begin
            v = 32'(int_mask);
        end
        for (int k = 0; k < battery_protection_pkg::N_CH; k++) begin
            if (a == 8'(battery_protection_pkg::LEVEL_BASE + 8 * k)) begin
                v = 32'(thr[k]);
            end
            if (a == 8'(battery_protection_pkg::LEVEL_BASE + 8 * k + 4)) begin
                v = 32'(rec[k]);
            end
            if (a == 8'(battery_protection_pkg::DELAY_BASE + 4 * k)) begin
                v = 32'(dly[k]);
            end
        end
        return v;
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= battery_protection_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_mux(s_axi_araddr_i);
            s_axi_rresp_o  <= addr_ok(s_axi_araddr_i) ? battery_protection_pkg::RESP_OKAY
                                                      : battery_protection_pkg::RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ****************************************
    // Millisecond tick
    // ****************************************
    logic [31:0] tick_cnt;
    logic        tick;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b0;
        end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    // ****************************************
    // Threshold comparisons
    // ****************************************
    logic [3:0] trip;
    logic [3:0] recov;
    logic [3:0] ch_en;
    logic [3:0] ch_flag;

    always_comb begin
        trip[battery_protection_pkg::CH_OV]   = meas_i.voltage >= thr[battery_protection_pkg::CH_OV];
        recov[battery_protection_pkg::CH_OV]  = meas_i.voltage <= rec[battery_protection_pkg::CH_OV];
        trip[battery_protection_pkg::CH_UV]   = meas_i.voltage <= thr[battery_protection_pkg::CH_UV];
        recov[battery_protection_pkg::CH_UV]  = meas_i.voltage >= rec[battery_protection_pkg::CH_UV];
        trip[battery_protection_pkg::CH_OTC]  = meas_i.temperature >= thr[battery_protection_pkg::CH_OTC];
        recov[battery_protection_pkg::CH_OTC] = meas_i.temperature <= rec[battery_protection_pkg::CH_OTC];
        trip[battery_protection_pkg::CH_OTD]  = meas_i.temperature >= thr[battery_protection_pkg::CH_OTD];
        recov[battery_protection_pkg::CH_OTD] = meas_i.temperature <= rec[battery_protection_pkg::CH_OTD];
        // Voltage checks always run; temperature checks stop at zero time
        ch_en[battery_protection_pkg::CH_OV]  = 1'b1;
        ch_en[battery_protection_pkg::CH_UV]  = 1'b1;
        ch_en[battery_protection_pkg::CH_OTC] = dly[battery_protection_pkg::CH_OTC] != 16'h0000;
        ch_en[battery_protection_pkg::CH_OTD] = dly[battery_protection_pkg::CH_OTD] != 16'h0000;
    end

    // ****************************************
    // Persistence timers and fault flags
    // ****************************************
    for (genvar k = 0; k < battery_protection_pkg::N_CH; k++) begin : g_ch
        logic [15:0] cnt;

        always_ff @(posedge ref_clk_i) begin
            if (rst_i || !ch_en[k]) begin
                cnt        <= 16'h0000;
                ch_flag[k] <= 1'b0;
            end else if (ch_flag[k]) begin
                cnt <= 16'h0000;
                if (recov[k]) begin
                    ch_flag[k] <= 1'b0;
                end
            end else if (!trip[k]) begin
                cnt <= 16'h0000;
            end else if (tick) begin
                if (cnt + 16'h0001 >= dly[k]) begin
                    ch_flag[k] <= 1'b1;
                    cnt        <= 16'h0000;
                end else begin
                    cnt <= cnt + 16'h0001;
                end
            end
        end
    end

    assign flags = {tab_disconnect_detect_i, internal_short_detect_i, ch_flag};

    // ****************************************
    // Switches and flag word
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            charge_switch_o    <= 1'b1;
            discharge_switch_o <= 1'b1;
            safety_flag_word_o <= 6'h00;
        end else begin
            charge_switch_o    <= !(ch_flag[battery_protection_pkg::CH_OV] ||
                                    (ch_flag[battery_protection_pkg::CH_OTC] &&
                                     ctrl.overtemp_opens_switch));
            discharge_switch_o <= !(ch_flag[battery_protection_pkg::CH_UV] ||
                                    (ch_flag[battery_protection_pkg::CH_OTD] &&
                                     ctrl.overtemp_opens_switch));
            safety_flag_word_o <= flags;
        end
    end

    // ****************************************
    // Interrupt status, mask and alert pin
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flags_prev       <= 6'h00;
            int_sts          <= 6'h00;
            irq_o            <= 1'b0;
            host_alert_pin_o <= 1'b0;
        end else begin
            flags_prev <= flags;
            // New events win over a clear in the same cycle
            int_sts    <= (int_sts & ~sts_clr) | (flags & ~flags_prev);
            irq_o      <= |(int_sts & int_mask);
            host_alert_pin_o <= ctrl.host_interrupt_enable &&
                                !ctrl.battery_trip_point_enable &&
                                |(int_sts & int_mask &
                                  battery_protection_pkg::ALERT_SOURCES);
        end
    end

endmodule

//--- bench/battery_protection_checker.sv
`timescale 1ns/1ns
module battery_protection_checker #(
    parameter int TICK_CYCLES = battery_protection_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    // Register bus
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    // Protection side
    input wire logic        internal_short_detect_i,
    input wire logic        charge_switch_o,
    input wire logic        discharge_switch_o,
    input wire logic [5:0]  safety_flag_word_o,
    input wire logic        irq_o,
    input wire logic        host_alert_pin_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_ov_opens_chg: assert property (safety_flag_word_o[0] |-> !charge_switch_o)
        else $error("charge switch closed during overvoltage");
    a_uv_opens_dsg: assert property (safety_flag_word_o[1] |-> !discharge_switch_o)
        else $error("discharge switch closed during undervoltage");
    a_chg_open_cause: assert property (!charge_switch_o
        |-> safety_flag_word_o[0] || safety_flag_word_o[2])
        else $error("charge switch open without a fault");
    a_dsg_open_cause: assert property (!discharge_switch_o
        |-> safety_flag_word_o[1] || safety_flag_word_o[3])
        else $error("discharge switch open without a fault");
    a_short_flag: assert property ($rose(internal_short_detect_i) |-> ##[1:3] safety_flag_word_o[4])
        else $error("internal short flag missing");
    a_alert_irq: assert property ($rose(host_alert_pin_o) |-> ##[0:1] irq_o)
        else $error("alert without interrupt");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    a_wr_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write accepted while response pending");
    a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
endmodule

bind battery_protection battery_protection_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

//--- bench/battery_switch_model.sv
`timescale 1ns/1ns
module battery_switch_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Host alert line
    input  wire logic       host_alert_pin_i,
    output logic [7:0]      alert_count_o
);
    logic alert_q;

    // Host side counts each alert it sees
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alert_q       <= 1'h0;
            alert_count_o <= 8'h00;
        end else begin
            alert_q <= host_alert_pin_i;
            if (host_alert_pin_i && !alert_q) begin
                alert_count_o <= alert_count_o + 8'h01;
            end
        end
    end
endmodule

//--- bench/tb_battery_protection.sv
`timescale 1ns/1ns
module tb_battery_protection;
    logic ref_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic sc = 1'h0, td = 1'h0;
    battery_protection_pkg::meas_t meas = '0;
    logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, chg, dsg, irq, alert;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    logic [5:0] flags;
    logic [7:0] alerts;
    int mismatches = 0;
    int tests_run = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    battery_protection #(.TICK_CYCLES(4)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(aw_rdy),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_vld),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
        .s_axi_rvalid_o(r_vld), .s_axi_rready_i(rready), .meas_i(meas),
        .internal_short_detect_i(sc), .tab_disconnect_detect_i(td),
        .charge_switch_o(chg), .discharge_switch_o(dsg), .safety_flag_word_o(flags),
        .irq_o(irq), .host_alert_pin_o(alert));
    battery_switch_model far (.clk_i(ref_clk_i), .rst_i(rst_i),
        .host_alert_pin_i(alert), .alert_count_o(alerts));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang;
        mismatches++;
        end_of_test();
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        int n;
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk_i);
            if (awvalid && aw_rdy) awvalid <= 1'h0;
            if (wvalid && w_rdy) wvalid <= 1'h0;
            if (b_vld) break;
        end
        if (n == 40) hang();
        bready <= 1'h0;
        chk(b_resp, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        int n;
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk_i);
            if (arvalid && ar_rdy) arvalid <= 1'h0;
            if (r_vld) break;
        end
        if (n == 40) hang();
        rready <= 1'h0;
        chk(r_data, d);
        chk(r_resp, r);
    endtask

    task automatic wait_flag(input int b, input logic v);
        int n;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk_i);
            if (flags[b] === v) break;
        end
        if (n == 100) hang();
        chk(flags[b], v);
    endtask

    task automatic set_v(input logic [15:0] v);
        @(posedge ref_clk_i);
        meas.voltage <= v;
    endtask

    task automatic set_t(input logic [15:0] t);
        @(posedge ref_clk_i);
        meas.temperature <= t;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        rd(8'h00, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'hffff);
        rd(8'h18, 32'h0);
        rd(8'h30, 32'h1);
        rd(8'h38, 32'h0);
        rd(8'h40, 32'h0, 2'h2);
        rd(8'h02, 32'h0, 2'h2);
        wr(8'h41, 32'h5, 2'h2);
        $display("registers done");
    endtask

    task automatic t_ov;
        wr(8'h10, 32'h1000);
        wr(8'h14, 32'h0800);
        wr(8'h30, 32'h3);
        set_v(16'h1000);
        step(6);
        set_v(16'h0900);
        step(1);
        set_v(16'h1000);
        step(6);
        set_v(16'h0900);
        step(2);
        chk(flags[0], 1'h0);
        set_v(16'h1000);
        wait_flag(0, 1'h1);
        chk(chg, 1'h0);
        set_v(16'h0801);
        step(10);
        chk(flags[0], 1'h1);
        set_v(16'h0800);
        wait_flag(0, 1'h0);
        chk(chg, 1'h1);
        $display("overvoltage done");
    endtask

    task automatic t_uv;
        wr(8'h18, 32'h0500);
        wr(8'h1c, 32'h0600);
        wr(8'h34, 32'h0);
        set_v(16'h0500);
        wait_flag(1, 1'h1);
        chk(dsg, 1'h0);
        set_v(16'h05ff);
        step(10);
        chk(flags[1], 1'h1);
        set_v(16'h0600);
        wait_flag(1, 1'h0);
        chk(dsg, 1'h1);
        $display("undervoltage done");
    endtask

    task automatic t_otc;
        wr(8'h20, 32'h0200);
        wr(8'h24, 32'h0100);
        set_t(16'h0300);
        step(20);
        chk(flags[2], 1'h0);
        wr(8'h38, 32'h2);
        wait_flag(2, 1'h1);
        chk(chg, 1'h1);
        set_t(16'h0100);
        wait_flag(2, 1'h0);
        $display("charge overtemperature done");
    endtask

    task automatic t_otd;
        wr(8'h00, 32'h1);
        wr(8'h28, 32'h0200);
        wr(8'h2c, 32'h0100);
        wr(8'h3c, 32'h1);
        set_t(16'h0300);
        wait_flag(3, 1'h1);
        chk(dsg, 1'h0);
        wait_flag(2, 1'h1);
        chk(chg, 1'h0);
        set_t(16'h0100);
        wait_flag(3, 1'h0);
        wait_flag(2, 1'h0);
        step(1);
        chk({chg, dsg}, 2'h3);
        $display("discharge overtemperature done");
    endtask

    task automatic t_irq;
        logic [7:0] seen;
        wr(8'h00, 32'h2);
        wr(8'h08, 32'h3f);
        wr(8'h0c, 32'h3f);
        step(2);
        chk(irq, 1'h0);
        sc <= 1'h1;
        wait_flag(4, 1'h1);
        step(2);
        chk({irq, alert}, 2'h3);
        rd(8'h08, 32'h10);
        wr(8'h00, 32'h0);
        step(2);
        chk({irq, alert}, 2'h2);
        wr(8'h00, 32'h6);
        step(2);
        chk({irq, alert}, 2'h2);
        wr(8'h0c, 32'h0);
        step(2);
        chk({irq, alert}, 2'h0);
        sc <= 1'h0;
        wr(8'h08, 32'h3f);
        wr(8'h0c, 32'h3f);
        wr(8'h00, 32'h2);
        td <= 1'h1;
        wait_flag(5, 1'h1);
        td <= 1'h0;
        wait_flag(5, 1'h0);
        wr(8'h3c, 32'h0);
        wr(8'h08, 32'h3f);
        step(2);
        chk({irq, alert}, 2'h0);
        seen = alerts;
        set_t(16'h0300);
        wait_flag(2, 1'h1);
        step(2);
        chk(alert, 1'h1);
        chk(alerts, seen + 8'h01);
        set_t(16'h0100);
        $display("interrupts done");
    endtask

    initial begin
        step(8);
        rst_i <= 1'h0;
        t_regs();
        t_ov();
        t_uv();
        t_otc();
        t_otd();
        t_irq();
        end_of_test();
    end
endmodule
